// file: logic/vom_pkg.sv
// package: register map, field positions and reset values of the output mode block
package vom_pkg;
  // printed offsets are not all multiples of four: these are indices
  localparam logic [7:0] VOM_IDX_MODE  = 8'h49;
  localparam logic [7:0] VOM_IDX_SWING = 8'h4B;
  localparam logic [7:0] VOM_IDX_LT1   = 8'h52;
  localparam logic [7:0] VOM_IDX_LTEN  = 8'h56;
  localparam logic [7:0] VOM_IDX_LT2   = 8'h57;
  localparam int VOM_ADDR_W = 10;
  localparam int VOM_STRAP_POS    = 7;
  localparam int VOM_OVR_POS      = 6;
  localparam int VOM_MAPREG_POS   = 5;
  localparam int VOM_LTPORT_POS   = 7;
  localparam int VOM_LTEN_POS     = 3;
  localparam logic [1:0] VOM_SWING_RST = 2'h0;
  localparam logic [1:0] VOM_LTFLD_RST = 2'h0;
  localparam logic [1:0] VOM_LTFLD_P0  = 2'h1;
  localparam logic [1:0] VOM_LTFLD_P1  = 2'h2;
  typedef enum logic [1:0] {
    VOM_DUAL      = 2'b00,
    VOM_DUAL_SWAP = 2'b01,
    VOM_SINGLE    = 2'b10,
    VOM_REPLICATE = 2'b11
  } vom_arr_t;
  // apb slave handshake states
  typedef enum logic [0:0] {
    VOM_IDLE = 1'b0,
    VOM_DONE = 1'b1
  } vom_st_t;
endpackage : vom_pkg

// file: logic/vom_top.sv
// output mode, swing and loop-through configuration registers over APB
`timescale 1ns/10ps
// How it works
// - bit 7 of the output mode register reads the strapped map-select level.
// - with override bit 6 set, map-select comes from bit 5; both reset to 0.
// - the 2-bit arrangement field picks dual, swapped, single or replicated.
// - the arrangement field's bit 0 is loaded from the mode strap at reset; bit 1 loads 0.
// - the 2-bit swing select resets to 00 and picks one of four swings.
// - loop-through source bit 7 chooses input port 0 (clear) or 1 (set).
// - the loop-through driver runs only when enable bit 3 is set; reset off.
// - source field 01 names port 0, 10 names port 1; it only flags a mismatch with bit 7.
module vom_top import vom_pkg::*; (
  input  wire logic                  clk,           // 250 MHz clock
  input  wire logic                  resetn,        // async reset, low
  input  wire logic                  mode_strap_pin,// mode strap pin
  input  wire logic                  psel,          // apb select
  input  wire logic                  penable,       // apb enable
  input  wire logic                  pwrite,        // apb direction
  input  wire logic [VOM_ADDR_W-1:0] paddr,         // apb byte address
  input  wire logic [31:0]           pwdata,        // apb write data
  input  wire logic [3:0]            pstrb,         // apb byte strobes
  output logic      [31:0]           prdata,        // apb read data
  output logic                       pready,        // apb ready
  output logic                       pslverr,       // apb error
  output logic      [1:0]            output_port_arrangement, // mode
  output logic                       map_select,    // effective map-select
  output logic      [1:0]            output_swing_select,     // swing
  output logic                       loopthrough_driver_enable, // driver on
  output logic                       loopthrough_from_port_one, // source
  output logic                       loopthrough_src_mismatch   // bit vs fld
);
  logic       rst_s1_r, rst_n_r;
  logic       strap_s1_r, strap_s2_r, strap_lvl_r;
  logic       strap_load_r;
  logic       ovr_r, mapreg_r, ltport_r, lten_r;
  logic [1:0] arr_r, swing_r, ltfld_r;
  vom_st_t    st_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // strap synchroniser runs through reset so it is settled at release
  always_ff @(posedge clk) begin
    strap_s1_r <= mode_strap_pin;
    strap_s2_r <= strap_s1_r;
  end

  // apb decode
  wire [7:0] idx       = paddr[VOM_ADDR_W-1:2];
  wire       aligned   = (paddr[1:0] == 2'h0);
  wire       hit_mode  = aligned && (idx == VOM_IDX_MODE);
  wire       hit_swing = aligned && (idx == VOM_IDX_SWING);
  wire       hit_lt1   = aligned && (idx == VOM_IDX_LT1);
  wire       hit_lten  = aligned && (idx == VOM_IDX_LTEN);
  wire       hit_lt2   = aligned && (idx == VOM_IDX_LT2);
  wire       mapped    = hit_mode | hit_swing | hit_lt1 | hit_lten | hit_lt2;
  wire       access    = psel && penable && (st_r == VOM_IDLE);
  // a write lands at the edge where the master sees pready high
  wire       wr        = psel && penable && (st_r == VOM_DONE) &&
                         pwrite && mapped && pstrb[0];

  wire [7:0] rd_mode  = {strap_lvl_r, ovr_r, mapreg_r,
                         3'h0, arr_r};
  wire [7:0] rd_swing = {6'h00, swing_r};
  wire [7:0] rd_lt1   = {ltport_r, 7'h00};
  wire [7:0] rd_lten  = {4'h0, lten_r, 3'h0};
  wire [7:0] rd_lt2   = {5'h00, ltfld_r, 1'b0};
  wire [7:0] rd_sel   = hit_mode  ? rd_mode  :
                        hit_swing ? rd_swing :
                        hit_lt1   ? rd_lt1   :
                        hit_lten  ? rd_lten  :
                        hit_lt2   ? rd_lt2   : 8'h00;

  // strap caught once after reset release; later pin moves change nothing
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      strap_load_r <= 1'b1;
      strap_lvl_r  <= 1'b0;
    end else if (strap_load_r) begin
      strap_load_r <= 1'b0;
      strap_lvl_r  <= strap_s2_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ovr_r    <= 1'b0;
      mapreg_r <= 1'b0;
      arr_r    <= VOM_DUAL;
      swing_r  <= VOM_SWING_RST;
      ltport_r <= 1'b0;
      lten_r   <= 1'b0;
      ltfld_r  <= VOM_LTFLD_RST;
    end else begin
      if (strap_load_r)
        arr_r <= {1'b0, strap_s2_r};
      else if (wr && hit_mode)
        arr_r <= pwdata[1:0];
      if (wr && hit_mode) begin
        ovr_r    <= pwdata[VOM_OVR_POS];
        mapreg_r <= pwdata[VOM_MAPREG_POS];
      end
      if (wr && hit_swing) swing_r  <= pwdata[1:0];
      if (wr && hit_lt1)   ltport_r <= pwdata[VOM_LTPORT_POS];
      if (wr && hit_lten)  lten_r   <= pwdata[VOM_LTEN_POS];
      if (wr && hit_lt2)   ltfld_r  <= pwdata[2:1];
    end
  end

  // one wait state: answer at the second access-phase edge
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      st_r    <= VOM_IDLE;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      case (st_r)
        VOM_IDLE: begin
          pready <= access;
          if (access) begin
            st_r    <= VOM_DONE;
            pslverr <= !mapped;
            prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_sel};
          end
        end
        VOM_DONE: begin
          st_r    <= VOM_IDLE;
          pready  <= 1'b0;
          pslverr <= 1'b0;
        end
        default: st_r <= VOM_IDLE;
      endcase
    end
  end

  // source field: 01 port 0, 10 port 1, checked against the bit; other codes never mismatch
  wire fld_p1 = (ltfld_r == VOM_LTFLD_P1);
  wire fld_ok = (ltfld_r == VOM_LTFLD_P0) || fld_p1;

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      output_port_arrangement   <= VOM_DUAL;
      map_select                <= 1'b0;
      output_swing_select       <= VOM_SWING_RST;
      loopthrough_driver_enable <= 1'b0;
      loopthrough_from_port_one <= 1'b0;
      loopthrough_src_mismatch  <= 1'b0;
    end else begin
      output_port_arrangement   <= arr_r;
      map_select                <= ovr_r ? mapreg_r : strap_lvl_r;
      output_swing_select       <= swing_r;
      loopthrough_driver_enable <= lten_r;
      loopthrough_from_port_one <= ltport_r;
      loopthrough_src_mismatch  <= fld_ok && (fld_p1 != ltport_r);
    end
  end

  a_map_override: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    ovr_r |=> map_select == $past(mapreg_r))
    else $error("map select not from register bit");
  a_map_strap: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    !ovr_r |=> map_select == $past(strap_lvl_r))
    else $error("map select not from strap");
  a_strap_read: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    (access && !pwrite && hit_mode) |=> prdata[7] == $past(strap_lvl_r))
    else $error("strap status wrong");
  a_swing_write: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    (wr && hit_swing) |=> ##1 output_swing_select == $past(pwdata[1:0], 2))
    else $error("swing not applied");
  a_arr_write: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    (wr && hit_mode && !strap_load_r) |=> ##1
    output_port_arrangement == $past(pwdata[1:0], 2))
    else $error("arrangement not applied");
  a_driver_en: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    (wr && hit_lten) |=> ##1
    loopthrough_driver_enable == $past(pwdata[VOM_LTEN_POS], 2))
    else $error("driver enable wrong");
  a_port_sel: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    (wr && hit_lt1) |=> ##1
    loopthrough_from_port_one == $past(pwdata[VOM_LTPORT_POS], 2))
    else $error("port select wrong");
  a_strap_load: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    strap_load_r |=> arr_r == {1'b0, $past(strap_s2_r)})
    else $error("strap not loaded");
  a_rsvd_zero: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    (access && !pwrite && hit_lten) |=> prdata[31:4] == 28'h0 &&
    prdata[2:0] == 3'h0)
    else $error("reserved bits nonzero");
  a_rsvd_mode: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    (access && !pwrite && hit_mode) |=> prdata[31:8] == 24'h0 &&
    prdata[4:2] == 3'h0)
    else $error("mode reserved bits nonzero");
  a_mismatch: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    (ltfld_r == VOM_LTFLD_P0 && ltport_r) |=> loopthrough_src_mismatch)
    else $error("mismatch not flagged");
  a_mismatch_port_one: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    (ltfld_r == VOM_LTFLD_P1 && !ltport_r) |=> loopthrough_src_mismatch)
    else $error("port one mismatch not flagged");
  a_ready_pulse: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    pready |=> !pready)
    else $error("ready held");
  a_write_ready: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    wr |-> pready)
    else $error("write outside ready edge");
  a_err_ready: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    pslverr |-> pready)
    else $error("error without ready");

  c_write: cover property (@(posedge clk) wr && hit_mode);
  c_read: cover property (@(posedge clk) access && !pwrite && mapped);
  c_error: cover property (@(posedge clk) pready && pslverr);
  c_override: cover property (@(posedge clk) ovr_r && map_select);
  c_mismatch: cover property (@(posedge clk) loopthrough_src_mismatch);
endmodule : vom_top

// file: tb/tb_top.sv
// self-checking bench for the output mode configuration registers
`timescale 1ns/10ps
module tb_top import vom_pkg::*;;
  logic                  clk, resetn, mode_strap_pin;
  logic                  psel, penable, pwrite;
  logic [VOM_ADDR_W-1:0] paddr;
  logic [31:0]           pwdata, prdata, rd;
  logic [3:0]            pstrb;
  logic                  pready, pslverr, er;
  logic [1:0]            arr, swing;
  logic                  msel, drv, p1, mis;
  int                    mismatches = 0, n_tests = 0, cyc = 0;
  wire  [7:0]            outs = {arr, msel, swing, drv, p1, mis};
  // rows: {index, write data, expected read, expected outputs}, strap high
  logic [31:0] rows [13] = '{32'h4963E3E0, 32'h4942C280, 32'h49008020,
    32'h49018160, 32'h4BFF0378, 32'h4B060270, 32'h52FF8072, 32'h57020273,
    32'h57040472, 32'h52000071, 32'h56FF0875, 32'h56F70071, 32'h57FF0670};
  logic [7:0]  idxs [5] = '{VOM_IDX_MODE, VOM_IDX_SWING, VOM_IDX_LT1,
    VOM_IDX_LTEN, VOM_IDX_LT2};
  vom_top u_dut (.clk(clk), .resetn(resetn), .mode_strap_pin(mode_strap_pin),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .output_port_arrangement(arr), .map_select(msel),
    .output_swing_select(swing), .loopthrough_driver_enable(drv),
    .loopthrough_from_port_one(p1), .loopthrough_src_mismatch(mis));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task conclude;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task chkb(input string nm, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %b seen %b", nm, exp, got);
    end
  endtask : chkb
  // one apb transfer; waits for pready under a bounded count
  task apb(input logic wr, input logic [9:0] a, input logic [31:0] d,
           input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chkb("pready", 1'b1, pready);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task do_reset(input logic s);
    logic [31:0] rexp;
    mode_strap_pin <= s;
    resetn <= 1'b0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (6) @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, {idxs[i], 2'b00}, 32'h0, 4'hF);
      rexp = (i == 0) ? {24'h0, s, 6'h0, s} : 32'h0;
      chk("reset read", rexp, rd);
    end
    chk("reset outs", {25'h0, s, s, 5'h0}, {24'h0, outs});
  endtask : do_reset
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    resetn = 1'b0; mode_strap_pin = 1'b1; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = '0; pwdata = '0; pstrb = '0;
    do_reset(1'b1);
    for (int i = 0; i < 13; i++) begin
      apb(1'b1, {rows[i][31:24], 2'b00}, {24'h0, rows[i][23:16]}, 4'hF);
      apb(1'b0, {rows[i][31:24], 2'b00}, 32'h0, 4'hF);
      chk("read", {24'h0, rows[i][15:8]}, rd);
      chk("outs", {24'h0, rows[i][7:0]}, {24'h0, outs});
      chkb("src mismatch", rows[i][0], mis);
    end
    // byte lane 0 not strobed: swing stays at 10
    apb(1'b1, {VOM_IDX_SWING, 2'b00}, 32'h0000_00FF, 4'hE);
    apb(1'b0, {VOM_IDX_SWING, 2'b00}, 32'h0, 4'hF);
    chk("masked write", 32'h0000_0002, rd);
    // unmapped index and misaligned address are refused
    apb(1'b0, {8'h50, 2'b00}, 32'h0, 4'hF);
    chkb("unmapped err", 1'b1, er);
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, 10'h125, 32'h0000_00FF, 4'hF);
    chkb("misaligned err", 1'b1, er);
    apb(1'b0, {VOM_IDX_MODE, 2'b00}, 32'h0, 4'hF);
    chk("mode kept", 32'h0000_0081, rd);
    // second reset with the strap low
    do_reset(1'b0);
    conclude();
  end
endmodule : tb_top
